// file: verilog/sfd_flash_cmd.sv
// Command logic for dual-output read and byte/page program
module sfd_flash_cmd
  import sfd_pkg::*;
#(
  parameter int PROG_CYC = PROG_BYTE_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Serial pins
  input wire logic csN,
  input wire logic sck,
  input wire logic serialIn,
  output logic serialOut,
  output logic serialOutOe,
  output logic second_data_pin,
  output logic secondDataOe,
  // Array protection and failure injection
  input wire logic protectAll,
  input wire logic failInject,
  // Status
  output sfd_status_t status
);
  logic [1:0] csSync;
  logic [1:0] sckSync;
  logic [1:0] sinSync;
  logic [1:0] failSync;
  logic [1:0] protSync;
  logic sckPrev_r;
  logic csPrev_r;
  logic rise;
  logic fall;
  logic csRise;
  logic csActive;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      csSync <= 2'h3;
      sckSync <= 2'h0;
      sinSync <= 2'h0;
      failSync <= 2'h0;
      protSync <= 2'h0;
      sckPrev_r <= 1'b0;
      csPrev_r <= 1'b1;
    end else begin
      csSync <= {csSync[0], csN};
      sckSync <= {sckSync[0], sck};
      sinSync <= {sinSync[0], serialIn};
      failSync <= {failSync[0], failInject};
      protSync <= {protSync[0], protectAll};
      sckPrev_r <= sckSync[1];
      csPrev_r <= csSync[1];
    end
  end

  assign csActive = ~csSync[1];
  assign rise = csActive & sckSync[1] & ~sckPrev_r; // [RL21]
  assign fall = csActive & ~sckSync[1] & sckPrev_r; // [RL21]
  assign csRise = csSync[1] & ~csPrev_r;

  sfd_state_t state_r;
  logic [7:0] shift_r;
  logic [2:0] bitCnt_r;
  logic [1:0] addrCnt_r;
  logic [7:0] opcode_r;
  logic [ADDR_W-1:0] addr_r;
  logic [7:0] rdByte_r;
  logic [1:0] pairCnt_r;
  logic [4:0] actCnt_r;
  logic [7:0] pageBuf [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] loaded_r;
  logic [8:0] dataCnt_r;
  logic [7:0] wrIdx_r;
  logic [ADDR_W-1:0] startAddr_r;
  logic [7:0] array_m [2**ADDR_W];
  logic [7:0] shiftNxt;
  logic byteDone;

  assign shiftNxt = {shift_r[6:0], sinSync[1]};
  assign byteDone = rise & (bitCnt_r == 3'h7);

  // Programming engine
  logic progRun_r;
  logic [8:0] progIdx_r;
  logic [15:0] progCnt_r;
  logic startProg;
  logic abortProg;
  logic setWel;
  logic clrWel;
  logic progFail;
  logic progOk;

  assign progOk = (opcode_r == OP_PROGRAM) && (state_r == SFD_PDATA)
    && (dataCnt_r != 9'h0) && (bitCnt_r == 3'h0); // [RL12]
  assign startProg = csRise && progOk && !protSync[1]
    && status.writeEnableLatch; // [RL7] [RL13]
  assign abortProg = csRise && (opcode_r == OP_PROGRAM)
    && !(progOk && !protSync[1]); // [RL12] [RL13]

  // Command framing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= SFD_OPC;
      shift_r <= 8'h0;
      bitCnt_r <= 3'h0;
      addrCnt_r <= 2'h0;
      opcode_r <= 8'h0;
      addr_r <= '0;
      startAddr_r <= '0;
      dataCnt_r <= 9'h0;
      wrIdx_r <= 8'h0;
      actCnt_r <= 5'h0;
    end else if (!csActive) begin
      state_r <= SFD_OPC; // [RL5]
      bitCnt_r <= 3'h0;
      addrCnt_r <= 2'h0;
      if (!csRise) begin
        opcode_r <= 8'h0;
      end
    end else if (rise) begin
      shift_r <= shiftNxt;
      bitCnt_r <= bitCnt_r + 3'h1;
      if (state_r == SFD_STAT) begin
        actCnt_r <= (actCnt_r == 5'h1f) ? actCnt_r : actCnt_r + 5'h1;
      end
      if (byteDone) begin
        case (state_r)
          SFD_OPC: begin
            opcode_r <= shiftNxt;
            actCnt_r <= 5'h8;
            dataCnt_r <= 9'h0;
            if (status.busy) begin
              state_r <= (shiftNxt == OP_STATUS
                || shiftNxt == OP_ACT_STATUS) ? SFD_STAT : SFD_IGNORE; // [RL16]
            end else if (shiftNxt == OP_DUAL_READ
                || shiftNxt == OP_PROGRAM) begin
              state_r <= SFD_ADDR; // [RL1] [RL8]
            end else if (shiftNxt == OP_STATUS
                || shiftNxt == OP_ACT_STATUS) begin
              state_r <= SFD_STAT;
            end else begin
              state_r <= SFD_IGNORE;
            end
          end
          SFD_ADDR: begin
            addr_r <= {addr_r[ADDR_W-9:0], shiftNxt};
            addrCnt_r <= addrCnt_r + 2'h1;
            if (addrCnt_r == 2'h2) begin
              if (opcode_r == OP_DUAL_READ) begin
                state_r <= SFD_DUMMY; // [RL2]
              end else begin
                state_r <= SFD_PDATA;
                startAddr_r <= {addr_r[ADDR_W-9:0], shiftNxt};
                wrIdx_r <= shiftNxt;
              end
            end
          end
          SFD_DUMMY: begin
            state_r <= SFD_RDATA;
          end
          SFD_PDATA: begin
            wrIdx_r <= wrIdx_r + 8'h1; // [RL9]
            if (dataCnt_r != 9'h100) begin
              dataCnt_r <= dataCnt_r + 9'h1;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Page buffer and loaded-byte map
  always_ff @(posedge clk) begin
    if (csActive && byteDone && state_r == SFD_PDATA) begin
      pageBuf[wrIdx_r] <= shiftNxt; // [RL10]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      loaded_r <= '0;
    end else if (csActive && byteDone && state_r == SFD_ADDR
        && addrCnt_r == 2'h2) begin
      loaded_r <= '0;
    end else if (csActive && byteDone && state_r == SFD_PDATA) begin
      loaded_r[wrIdx_r] <= 1'b1; // [RL11]
    end
  end

  // Dual read data path
  logic [ADDR_W-1:0] rdAddr_r;
  logic rdDrive_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdAddr_r <= '0;
      pairCnt_r <= 2'h0;
      rdByte_r <= 8'h0;
      rdDrive_r <= 1'b0;
      serialOut <= 1'b0;
      second_data_pin <= 1'b0;
      serialOutOe <= 1'b0;
      secondDataOe <= 1'b0;
    end else if (!csActive) begin
      rdDrive_r <= 1'b0;
      serialOutOe <= 1'b0; // [RL5]
      secondDataOe <= 1'b0; // [RL5]
      pairCnt_r <= 2'h0;
      if (state_r == SFD_STAT && actCnt_r >= 5'(ACT_STATUS_CLKS)
          && !status.busy && opcode_r == OP_ACT_STATUS) begin
        serialOut <= 1'b0;
      end
    end else begin
      if (byteDone && state_r == SFD_DUMMY) begin
        rdByte_r <= array_m[addr_r];
        rdAddr_r <= (addr_r == ARRAY_LAST) ? '0 : addr_r + 1'b1;
        rdDrive_r <= 1'b1;
      end
      if (fall && rdDrive_r && state_r == SFD_RDATA) begin
        serialOut <= rdByte_r[7]; // [RL3]
        second_data_pin <= rdByte_r[6]; // [RL3]
        serialOutOe <= 1'b1;
        secondDataOe <= 1'b1;
        pairCnt_r <= pairCnt_r + 2'h1;
        if (pairCnt_r == 2'h3) begin
          rdByte_r <= array_m[rdAddr_r];
          rdAddr_r <= (rdAddr_r == ARRAY_LAST) ? '0 : rdAddr_r + 1'b1; // [RL4]
        end else begin
          rdByte_r <= {rdByte_r[5:0], 2'b00};
        end
      end
      if (fall && state_r == SFD_STAT) begin
        serialOutOe <= 1'b1;
        serialOut <= (opcode_r == OP_ACT_STATUS)
          ? ((actCnt_r >= 5'(ACT_STATUS_CLKS)) ? status.busy : 1'b1)
          : status.busy; // [RL16] [RL18]
      end
      if (state_r == SFD_STAT && opcode_r == OP_ACT_STATUS
          && actCnt_r >= 5'(ACT_STATUS_CLKS) && !status.busy) begin
        serialOut <= 1'b0; // [RL18]
      end
    end
  end

  // Self-timed array programming
  logic [ADDR_W-1:0] progAddr;
  assign progAddr = {startAddr_r[ADDR_W-1:8], progIdx_r[7:0]};
  assign progFail = failSync[1];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      progRun_r <= 1'b0;
      progIdx_r <= 9'h0;
      progCnt_r <= 16'h0;
    end else if (startProg) begin
      progRun_r <= 1'b1; // [RL15]
      progIdx_r <= 9'h0;
      progCnt_r <= 16'(PROG_CYC);
    end else if (progRun_r) begin
      if (progIdx_r == 9'(PAGE_BYTES)) begin
        progRun_r <= 1'b0;
      end else if (!loaded_r[progIdx_r[7:0]]) begin
        progIdx_r <= progIdx_r + 9'h1; // [RL11]
      end else if (progCnt_r > 16'h1) begin
        progCnt_r <= progCnt_r - 16'h1;
      end else begin
        progCnt_r <= 16'(PROG_CYC);
        progIdx_r <= progIdx_r + 9'h1;
      end
    end
  end

  // Array starts fully erased; it is written only by the programming engine
  initial begin
    for (int i = 0; i < 2**ADDR_W; i++) begin
      array_m[i] = ERASED_BYTE; // [RL6] [RL11]
    end
  end

  always @(posedge clk) begin
    if (progRun_r && progIdx_r != 9'(PAGE_BYTES)
        && loaded_r[progIdx_r[7:0]] && progCnt_r == 16'h1) begin
      array_m[progAddr] <= array_m[progAddr]
        & pageBuf[progIdx_r[7:0]]; // [RL6]
    end
  end

  // Status bits
  assign setWel = csRise && opcode_r == OP_WR_ENABLE && !status.busy;
  assign clrWel = (csRise && opcode_r == OP_WR_DISABLE && !status.busy)
    || abortProg || startProg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status <= '0;
    end else begin
      status.busy <= startProg | (progRun_r
        & ~(progIdx_r == 9'(PAGE_BYTES))); // [RL16]
      if (clrWel) begin
        status.writeEnableLatch <= 1'b0; // [RL14] [RL19]
      end else if (setWel) begin
        status.writeEnableLatch <= 1'b1;
      end
      if (progRun_r && progIdx_r != 9'(PAGE_BYTES)
          && loaded_r[progIdx_r[7:0]] && progCnt_r == 16'h1
          && progFail) begin
        status.programEraseErrorFlag <= 1'b1; // [RL20]
      end else if (startProg) begin
        status.programEraseErrorFlag <= 1'b0;
      end
    end
  end
endmodule : sfd_flash_cmd

// file: inc/sfd_pkg.sv
// Package of constants and types for the serial flash command logic
// Summary of operation
// RL1 - Dual read: chip select, opcode 3Bh, then three address bytes.
// RL2 - Dual read needs one dummy byte after the address before data.
// RL3 - Dual read sends two bits per clock, MSB first on main output.
// RL4 - Read address wraps from 07FFFFh to 000000h without delay.
// RL5 - Chip select release ends dual read and floats both data pins.
// RL6 - Program writes 1 to 256 bytes into erased FFh locations.
// RL7 - Host must set write enable latch before a program command.
// RL8 - Program is opcode 02h, three address bytes, data into page buffer.
// RL9 - Program data past page end wraps to the same page start.
// RL10 - More than 256 data bytes: buffer keeps the last 256.
// RL11 - On release, buffered bytes are programmed; unsent bytes stay FFh.
// RL12 - Abort on short address, no full data byte, or uneven release.
// RL13 - Protected target: program not executed, return to idle.
// RL14 - Any program abort or protection refusal clears write enable latch.
// RL15 - Array programming is self-timed after chip select rises.
// RL16 - While programming, status reads are accepted and show busy.
// RL17 - Host should poll status rather than wait worst-case time.
// RL18 - Command 25h: after 16 clocks, output driven low when busy ends.
// RL19 - Write enable latch cleared before the program cycle completes.
// RL20 - Failed byte programming sets the program/erase error flag.
// RL21 - Inputs sampled on rising clock edge, outputs launched on falling.
package sfd_pkg;
  localparam logic [7:0] OP_DUAL_READ = 8'h3b;
  localparam logic [7:0] OP_PROGRAM = 8'h02;
  localparam logic [7:0] OP_STATUS = 8'h05;
  localparam logic [7:0] OP_WR_ENABLE = 8'h06;
  localparam logic [7:0] OP_WR_DISABLE = 8'h04;
  localparam logic [7:0] OP_ACT_STATUS = 8'h25;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam int ADDR_W = 19;
  localparam logic [ADDR_W-1:0] ARRAY_LAST = 19'h7ffff;
  localparam int PAGE_BYTES = 256;
  localparam int ACT_STATUS_CLKS = 16;
  localparam int STS_BUSY_BIT = 0;
  localparam int STS_WEL_BIT = 1;
  localparam int STS_EPE_BIT = 5;
  localparam int CLK_MHZ = 200;
  localparam int PROG_BYTE_NS = 200;
  localparam int PROG_BYTE_CYC = (PROG_BYTE_NS * CLK_MHZ) / 1000;

  typedef enum logic [2:0] {
    SFD_OPC = 3'b000,
    SFD_ADDR = 3'b001,
    SFD_DUMMY = 3'b011,
    SFD_RDATA = 3'b010,
    SFD_PDATA = 3'b110,
    SFD_STAT = 3'b111,
    SFD_IGNORE = 3'b101
  } sfd_state_t;

  typedef struct packed {
    logic busy;
    logic writeEnableLatch;
    logic programEraseErrorFlag;
  } sfd_status_t;
endpackage : sfd_pkg

// file: verification/sfd_host.sv
// Host model driving the serial pins of the flash command logic
module sfd_host (
  // Serial pins
  output logic csN,
  output logic sck,
  output logic serialIn,
  input wire logic serialOut,
  input wire logic second_data_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [63:0] q;
  initial begin
    csN = 1'b1;
    sck = 1'b0;
    serialIn = 1'b0;
    q = '0;
  end
  task open;
    csN = 1'b0;
    #24;
  endtask : open
  // Sends n bits MSB first, opcode then address, dummy or data
  task bits(input logic [63:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      serialIn = v[63-i];
      #24 sck = 1'b1;
      q = {q[62:0], serialOut};
      #24 sck = 1'b0;
    end
  endtask : bits
  task dual(input int n);
    for (int i = 0; i < n; i++) begin
      // Input line released during dual output: keep it moving
      serialIn = ~serialIn;
      #24 sck = 1'b1;
      q = {q[61:0], serialOut, second_data_pin};
      #24 sck = 1'b0;
    end
  endtask : dual
  task close;
    csN = 1'b1;
    serialIn = ~serialIn;
    #48;
  endtask : close
endmodule : sfd_host

// file: verification/sfd_flash_cmd_chk.sv
// Port assertions for the serial flash command logic
module sfd_flash_cmd_chk
  import sfd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Serial pins
  input wire logic csN,
  input wire logic sck,
  input wire logic serialIn,
  input wire logic serialOut,
  input wire logic serialOutOe,
  input wire logic second_data_pin,
  input wire logic secondDataOe,
  // Control and status
  input wire logic protectAll,
  input wire logic failInject,
  input wire sfd_status_t status
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence csIdle;
    csN [*8];
  endsequence
  sequence busyEnd;
    $fell(status.busy) && !csN && serialOutOe;
  endsequence
  idle_float_a: assert property (csIdle |-> !serialOutOe && !secondDataOe)
    else $error("data pins driven while deselected");
  dual_pair_a: assert property (secondDataOe |-> serialOutOe)
    else $error("second pin driven without main pin");
  busy_cs_a: assert property ($rose(status.busy) |-> csN)
    else $error("programming began while selected");
  busy_bound_a: assert property ($rose(status.busy) |-> ##[1:1000] !status.busy)
    else $error("programming did not finish");
  busy_wel_a: assert property (status.busy [*3] |-> !status.writeEnableLatch)
    else $error("write enable left set while programming");
  ready_low_a: assert property (busyEnd |-> ##[0:4] !serialOut)
    else $error("ready not shown low after busy");
  epe_cause_a: assert property ($rose(status.programEraseErrorFlag) |-> $past(failInject))
    else $error("error flag set without a failure");
  prot_block_a: assert property ($rose(status.busy) |-> !protectAll)
    else $error("protected array was programmed");
endmodule : sfd_flash_cmd_chk

bind sfd_flash_cmd sfd_flash_cmd_chk u_chk (.clk, .rst, .csN, .sck, .serialIn,
  .serialOut, .serialOutOe, .second_data_pin, .secondDataOe, .protectAll,
  .failInject, .status);

// file: verification/tb.sv
// Testbench for the serial flash command logic
module tb
  import sfd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic protectAll = 1'b0;
  logic failInject = 1'b0;
  logic csN, sck, serialIn, serialOut, serialOutOe;
  logic second_data_pin, secondDataOe;
  sfd_status_t status;
  int num_errors = 0;
  int checks_done = 0;
  int abortBits[3] = '{24, 32, 43};
  always #2.5 clk = ~clk;
  sfd_flash_cmd #(.PROG_CYC(2)) u_dut (.clk, .rst, .csN, .sck, .serialIn,
    .serialOut, .serialOutOe, .second_data_pin, .secondDataOe, .protectAll,
    .failInject, .status);
  sfd_host u_host (.csN, .sck, .serialIn, .serialOut, .second_data_pin);
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task end_sim;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim
  task cmd(input logic [63:0] v, input int n);
    u_host.open();
    u_host.bits(v, n);
    u_host.close();
  endtask : cmd
  task prog(input logic [23:0] a, input logic [23:0] d, input int nb);
    cmd({OP_WR_ENABLE, 56'h0}, 8);
    cmd({OP_PROGRAM, a, d, 8'h0}, 32 + 8 * nb);
  endtask : prog
  task rd(input logic [23:0] a, input int n);
    u_host.open();
    u_host.bits({OP_DUAL_READ, a, 8'h0, 24'h0}, 40);
    u_host.dual(n);
    u_host.close();
  endtask : rd
  // Waits on the active status command until busy ends
  task ready;
    int i;
    u_host.open();
    u_host.bits({OP_ACT_STATUS, 56'h0}, 16);
    for (i = 0; i < 3000 && (status.busy !== 1'b0 || serialOut !== 1'b0); i++)
      @(posedge clk);
    if (i == 3000) begin
      num_errors++;
      end_sim();
    end
    chk("readyOe", {7'h0, serialOutOe}, 8'h1);
    u_host.close();
  endtask : ready
  initial begin
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge clk);
    chk("status", {5'h0, status}, 8'h0);
    cmd({OP_WR_ENABLE, 56'h0}, 8);
    chk("wel", {7'h0, status.writeEnableLatch}, 8'h1);
    prog(24'h07ffff, 24'h0f0000, 1);
    chk("busyWel", {6'h0, status.busy, status.writeEnableLatch}, 8'h2);
    cmd({OP_STATUS, 56'h0}, 16);
    chk("stsRead", {7'h0, u_host.q[STS_BUSY_BIT]}, 8'h1);
    ready();
    prog(24'h0000fe, 24'h3355f0, 3);
    ready();
    rd(24'h07ffff, 8);
    chk("wrapRd", u_host.q[15:8], 8'h0f);
    chk("pageWrap", u_host.q[7:0], 8'hf0);
    rd(24'h0000fe, 8);
    chk("pageLo", u_host.q[15:8], 8'h33);
    chk("pageHi", u_host.q[7:0], 8'h55);
    rd(24'h0000fe, 3);
    chk("floatOe", {6'h0, serialOutOe, secondDataOe}, 8'h0);
    rd(24'h000001, 4);
    chk("unsent", u_host.q[7:0], 8'hff);
    for (int k = 0; k < 3; k++) begin
      cmd({OP_WR_ENABLE, 56'h0}, 8);
      cmd({OP_PROGRAM, 24'h000300, 32'h0}, abortBits[k]);
      chk("abortSts", {5'h0, status}, 8'h0);
    end
    @(posedge clk);
    #1 protectAll = 1'b1;
    prog(24'h000300, 24'h0, 1);
    chk("protSts", {5'h0, status}, 8'h0);
    @(posedge clk);
    #1 protectAll = 1'b0;
    rd(24'h000300, 4);
    chk("noWrite", u_host.q[7:0], 8'hff);
    @(posedge clk);
    #1 failInject = 1'b1;
    prog(24'h000400, 24'h0, 1);
    ready();
    chk("epe", {7'h0, status.programEraseErrorFlag}, 8'h1);
    @(posedge clk);
    #1 failInject = 1'b0;
    end_sim();
  end
endmodule : tb
